// ===== verilog/cfl_cell.sv
// Configurable logic cell with APB register file
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
module cfl_cell
  import cfl_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Cell sources and results
  input wire logic [NUM_SRC-1:0] src_i,
  output logic cell_output_signal_o,
  output logic cell_irq_flag_o
);

  ////////////////////////////////////////////////////////////////////
  // Registers
  cfl_ctrl_t ctrl_r;
  logic out_inv_r;
  logic [NUM_CH-1:0] gate_inv_r;
  logic [SEL_W-1:0] sel_r [NUM_CH];
  logic [7:0] gate_en_r [NUM_CH];
  logic irq_flag_r;
  logic cell_out_r;
  logic out_prev_r;
  logic q_r;
  logic q_nxt;
  logic clk_prev_r;
  logic [31:0] prdata_r;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  cfl_apb_req_t req;
  assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

  wire setup_ph = req.psel && !req.penable;
  wire access_ph = req.psel && req.penable;
  wire wr_stb = access_ph && req.pwrite && ce_i;
  wire hit_ctrl = (req.paddr == ADDR_CONTROL);
  wire hit_pol = (req.paddr == ADDR_POLARITY);
  wire hit_irq = (req.paddr == ADDR_IRQ_STATUS);
  wire [NUM_CH-1:0] hit_sel;
  wire [NUM_CH-1:0] hit_gate;
  wire hit_any = hit_ctrl || hit_pol || hit_irq || (|hit_sel) || (|hit_gate);

  // Zero wait states; only access phase can flag an error
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph && !hit_any;

  ////////////////////////////////////////////////////////////////////
  // Per channel: address decode, source mux, gate
  wire [NUM_CH-1:0] chan_data;
  wire [NUM_CH-1:0] gate_out;
  wire [NUM_CH-1:0] gate_raw;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign hit_sel[gi] = (req.paddr == ADDR_SEL_BASE + 8'(gi) * ADDR_STEP);
      assign hit_gate[gi] = (req.paddr == ADDR_GATE_BASE + 8'(gi) * ADDR_STEP);
      // Reserved codes feed a constant zero; top source lines stay unused
      assign chan_data[gi] = (sel_r[gi] < RSVD_CODE_MIN) ? src_i[sel_r[gi]] : 1'b0; // see (RULE19)
    end
    for (gi = 0; gi < NUM_CH; gi++) begin : g_gate
      wire [NUM_CH-1:0] terms;
      genvar ci;
      for (ci = 0; ci < NUM_CH; ci++) begin : g_term
        // Pair 2ci+1 passes true data, 2ci negated data
        assign terms[ci] = (gate_en_r[gi][2*ci+1] & chan_data[ci]) |
                           (gate_en_r[gi][2*ci] & ~chan_data[ci]); // see (RULE14)
      end
      // Empty gate is 0, so its level is set by inversion alone
      assign gate_raw[gi] = |terms; // see (RULE17) see (RULE15)
      assign gate_out[gi] = gate_raw[gi] ^ gate_inv_r[gi]; // see (RULE12)
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Logic function; D flip-flop mode storage pins: clk=g1 d=g2 r=g3 s=g4
  wire g1 = gate_out[0];
  wire g2 = gate_out[1];
  wire g3 = gate_out[2];
  wire g4 = gate_out[3];
  wire clk_rise = g1 && !clk_prev_r;
  wire fn_comb_and_or = (g1 & g2) | (g3 & g4);
  wire fn_comb_or_xor = (g1 | g2) ^ (g3 | g4);
  wire fn_comb_and4 = &gate_out;

  // Storage next state; reset dominates set in every mode
  always_comb begin
    q_nxt = q_r;
    case (ctrl_r.function_select)
      FN_SR_LATCH: begin // see (RULE10) see (RULE20)
        if (g3 | g4) begin
          q_nxt = 1'b0;
        end else if (g1 | g2) begin
          q_nxt = 1'b1;
        end
      end
      FN_DFF_SR: begin
        if (g3) begin
          q_nxt = 1'b0;
        end else if (g4) begin
          q_nxt = 1'b1;
        end else if (clk_rise) begin
          q_nxt = g2;
        end
      end
      FN_DFF2_R: begin
        if (g3) begin
          q_nxt = 1'b0;
        end else if (clk_rise) begin
          q_nxt = g2 & g4;
        end
      end
      FN_JK_R: begin
        if (g3) begin
          q_nxt = 1'b0;
        end else if (clk_rise) begin
          q_nxt = (g2 & ~q_r) | (~g4 & q_r);
        end
      end
      FN_LATCH_SR: begin
        if (g3) begin
          q_nxt = 1'b0;
        end else if (g4) begin
          q_nxt = 1'b1;
        end else if (g1) begin
          q_nxt = g2;
        end
      end
      default: begin
        q_nxt = q_r;
      end
    endcase
  end

  // Function result before output inversion
  logic fn_result;
  always_comb begin
    case (ctrl_r.function_select)
      FN_AND_OR: fn_result = fn_comb_and_or; // see (RULE9)
      FN_OR_XOR: fn_result = fn_comb_or_xor;
      FN_AND4: fn_result = fn_comb_and4;
      default: fn_result = q_nxt;
    endcase
  end

  wire out_nxt = ctrl_r.cell_enable ? (fn_result ^ out_inv_r) : 1'b0; // see (RULE5) see (RULE11)

  ////////////////////////////////////////////////////////////////////
  // Edge detect; a clear in the same cycle as an edge loses
  wire rise_evt = cell_out_r && !out_prev_r && ctrl_r.rise_irq_enable; // see (RULE7)
  wire fall_evt = !cell_out_r && out_prev_r && ctrl_r.fall_irq_enable; // see (RULE8)
  wire irq_clr = wr_stb && hit_irq && req.pwdata[IRQ_FLAG_BIT];
  wire irq_nxt = (rise_evt || fall_evt) ? 1'b1 : (irq_clr ? 1'b0 : irq_flag_r); // see (RULE18)

  // Cell datapath and flag; disabling also clears stored state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cell_out_r <= 1'b0;
      out_prev_r <= 1'b0;
      q_r <= 1'b0;
      clk_prev_r <= 1'b0;
      irq_flag_r <= 1'b0;
    end else if (ce_i) begin
      cell_out_r <= out_nxt;
      out_prev_r <= cell_out_r; // see (RULE21)
      q_r <= ctrl_r.cell_enable ? q_nxt : 1'b0;
      clk_prev_r <= g1;
      irq_flag_r <= irq_nxt; // see (RULE21)
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and output inversion: cleared by every reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CONTROL_RST; // see (RULE16)
      out_inv_r <= OUT_INV_RST;
    end else if (wr_stb) begin
      if (hit_ctrl) begin
        ctrl_r <= req.pwdata[7:0];
      end
      if (hit_pol) begin
        out_inv_r <= req.pwdata[POL_OUT_BIT];
      end
    end
  end

  // Selection and gating survive reset, unknown at power-up
  always_ff @(posedge mclk_i) begin
    if (wr_stb) begin
      if (hit_pol) begin
        gate_inv_r <= req.pwdata[NUM_CH-1:0]; // see (RULE16)
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit_sel[i]) begin
          sel_r[i] <= req.pwdata[SEL_W-1:0]; // see (RULE13)
        end
        if (hit_gate[i]) begin
          gate_en_r[i] <= req.pwdata[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; bit 6 and the stored output copy never leak
  cfl_ctrl_t ctrl_rd;
  always_comb begin
    ctrl_rd = ctrl_r;
    ctrl_rd.unused6 = 1'b0; // see (RULE6)
    ctrl_rd.cell_output_bit = cell_out_r; // see (RULE6)
  end

  logic [31:0] rd_word;
  always_comb begin
    rd_word = RDATA_ZERO;
    if (hit_ctrl) begin
      rd_word[7:0] = ctrl_rd;
    end
    if (hit_pol) begin
      rd_word[POL_OUT_BIT] = out_inv_r;
      rd_word[NUM_CH-1:0] = gate_inv_r;
    end
    if (hit_irq) begin
      rd_word[IRQ_FLAG_BIT] = irq_flag_r;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit_sel[i]) begin
        rd_word[SEL_W-1:0] = sel_r[i]; // see (RULE13)
      end
      if (hit_gate[i]) begin
        rd_word[7:0] = gate_en_r[i];
      end
    end
  end

  // Read data captured in setup, stable through access
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prdata_r <= RDATA_ZERO;
    end else if (ce_i && setup_ph) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata_o = prdata_r;
  assign cell_output_signal_o = cell_out_r;
  assign cell_irq_flag_o = irq_flag_r;

endmodule // cfl_cell

// ===== verilog/cfl_pkg.sv
// Package for the configurable logic cell: register map, fields, reset values, types
// Summary of operation
// (RULE1) Software disables cell before reconfiguring, enables last
// (RULE2) Software clears pin analog select for inputs
// (RULE3) Software remaps pin and clears its direction
// (RULE4) Software sets edge and interrupt enables
// (RULE5) Enable bit 7; clear forces output zero
// (RULE6) Bit 5 reads output; bit 6 zero
// (RULE7) Bit 4 lets rising edge set flag
// (RULE8) Bit 3 lets falling edge set flag
// (RULE9) Codes 000-010: AND-OR, OR-XOR, 4-input AND
// (RULE10) Codes 011-111: latch and flip-flop modes
// (RULE11) Polarity bit 7 inverts the function result
// (RULE12) Polarity bits 3-0 invert gate outputs
// (RULE13) Source selects: 6-bit code, bits 7-6 zero
// (RULE14) Gate enable pairs: true upper, negated lower
// (RULE15) Gate registers map to their own gates
// (RULE16) Control and output invert reset; rest kept
// (RULE17) Empty gate gives constant from its inversion
// (RULE18) Flag sticky; edge during clear wins
// (RULE19) Forty sources; codes 37 up are reserved
// (RULE20) Storage modes use a fixed gate mapping
// (RULE21) Edges sampled on clock; flag next cycle
package cfl_pkg;

  // Byte addresses on the APB
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_POLARITY = 8'h04;
  localparam logic [7:0] ADDR_SEL_BASE = 8'h08;
  localparam logic [7:0] ADDR_GATE_BASE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_STEP = 8'h04;

  // Sizes
  localparam int NUM_CH = 4;
  localparam int NUM_SRC = 40;
  localparam int SEL_W = 6;
  localparam logic [SEL_W-1:0] RSVD_CODE_MIN = 6'h25; // Codes from here up select nothing

  // Field positions
  localparam int POL_OUT_BIT = 7;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int WORD_BIT = 2;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic OUT_INV_RST = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Function select codes
  localparam logic [2:0] FN_AND_OR = 3'h0;
  localparam logic [2:0] FN_OR_XOR = 3'h1;
  localparam logic [2:0] FN_AND4 = 3'h2;
  localparam logic [2:0] FN_SR_LATCH = 3'h3;
  localparam logic [2:0] FN_DFF_SR = 3'h4;
  localparam logic [2:0] FN_DFF2_R = 3'h5;
  localparam logic [2:0] FN_JK_R = 3'h6;
  localparam logic [2:0] FN_LATCH_SR = 3'h7;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic cell_enable;
    logic unused6;
    logic cell_output_bit;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [2:0] function_select;
  } cfl_ctrl_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cfl_apb_req_t;

endpackage

// ===== verif/cfl_cell_props.sv
// Port checker for the logic cell
`timescale 1ns/1ns
module cfl_cell_props
  import cfl_pkg::*;
(
  // Clock, reset, APB
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Cell
  input wire logic [NUM_SRC-1:0] src_i,
  input wire logic cell_output_signal_o,
  input wire logic cell_irq_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // Decode; shadow enables track writes so edges are judged as the cell sees them
  wire o = cell_output_signal_o;
  wire f = cell_irq_flag_o;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i && ce_i;
  wire rd = acc && !pwrite_i;
  wire map = paddr_i <= ADDR_IRQ_STATUS && paddr_i[1:0] == 2'h0;
  wire clr = wr && paddr_i == ADDR_IRQ_STATUS && pwdata_i[IRQ_FLAG_BIT];
  wire sel = paddr_i >= ADDR_SEL_BASE && paddr_i < ADDR_GATE_BASE;
  logic en_r, ri_r, fa_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) {en_r, ri_r, fa_r} <= 3'h0;
    else if (wr && paddr_i == ADDR_CONTROL) {en_r, ri_r, fa_r} <= {pwdata_i[7], pwdata_i[4:3]};
  end
  ////////////////////////////////////////
  // Properties
  property p_dis; (!en_r && ce_i) |=> !o; endproperty
  a_dis: assert property (p_dis) else $error("output high while disabled");
  property p_rise; ($rose(o) && ri_r && ce_i) |-> ##1 f; endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall; ($fell(o) && fa_r && ce_i) |-> ##1 f; endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_cause; $rose(f) |-> $past(o) != $past(o, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag without edge");
  property p_stick; (f && !clr) |=> f; endproperty
  a_stick: assert property (p_stick) else $error("flag dropped");
  property p_err; acc |-> pslverr_o == !map; endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_hi; rd |-> prdata_o[31:8] == 24'h0 && (paddr_i != ADDR_CONTROL || !prdata_o[6]);
  endproperty
  a_hi: assert property (p_hi) else $error("unused bits set");
  property p_sel; (rd && sel) |-> prdata_o[7:6] == 2'h0; endproperty
  a_sel: assert property (p_sel) else $error("select top bits set");
  c_irq: cover property ($rose(f));
  c_err: cover property (acc && pslverr_o);
  c_dis: cover property ($fell(o) && !en_r);
endmodule // cfl_cell_props

bind cfl_cell cfl_cell_props u_props (.mclk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .src_i, .cell_output_signal_o,
  .cell_irq_flag_o);

// ===== verif/cfl_cell_tb.sv
// Self-checking bench for the logic cell
`timescale 1ns/1ns
module cfl_cell_tb;
  import cfl_pkg::*;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, out_o, flag_o, err;
  logic [NUM_SRC-1:0] src_i = '0;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  cfl_cell u_dut (.mclk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .src_i, .cell_output_signal_o(out_o),
    .cell_irq_flag_o(flag_o));
  ////////////////////////////////////////
  // Clock and hang guard
  initial forever #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer; held until pready is seen
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Disable first, channel k to gate k true, then polarity
  task automatic cfg(logic [7:0] p);
    apb(1, ADDR_CONTROL, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, ADDR_SEL_BASE + 8'(4 * k), k);
      apb(1, ADDR_GATE_BASE + 8'(4 * k), 32'h2 << (2 * k));
    end
    apb(1, ADDR_POLARITY, p);
  endtask
  function automatic logic model(int fn, logic [7:0] p, logic [3:0] v);
    logic [3:0] g;
    g = v ^ p[3:0];
    if (fn == 0) return ((g[0] & g[1]) | (g[2] & g[3])) ^ p[7];
    else if (fn == 1) return ((g[0] | g[1]) ^ (g[2] | g[3])) ^ p[7];
    else return (&g) ^ p[7];
  endfunction
  ////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    apb(0, ADDR_CONTROL, 0);
    chk("ctrl rst", 0, rd);
    apb(0, ADDR_POLARITY, 0);
    chk("pol rst", 0, {rd[31:4], 4'h0});
    apb(1, ADDR_SEL_BASE, 32'hFF);
    apb(0, ADDR_SEL_BASE, 0);
    chk("sel", 32'h3F, rd);
    apb(1, ADDR_POLARITY, 32'hFF);
    apb(0, ADDR_POLARITY, 0);
    chk("pol", 32'h8F, rd);
    apb(1, ADDR_CONTROL, 32'h60);
    apb(0, ADDR_CONTROL, 0);
    chk("ctrl ro", 0, rd);
    apb(0, 8'h2C, 0);
    chk("unmapped", 1, {rd[30:0], err});
    $display("t_regs done");
  endtask
  task automatic t_comb;
    logic [7:0] p;
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'h85 : 8'h00;
      cfg(p);
      for (int f = 0; f < 3; f++) begin
        apb(1, ADDR_CONTROL, 32'h80 | f);
        for (int v = 0; v < 16; v++) begin
          src_i[3:0] <= 4'(v);
          tick(3);
          chk("comb", model(f, p, 4'(v)), out_o);
        end
      end
    end
    $display("t_comb done");
  endtask
  task automatic t_store;
    logic [15:0] sq[5] = '{16'h1040, 16'h2304, 16'h2BA4, 16'h2389, 16'h2318};
    logic [3:0] ex[5] = '{4'hC, 4'h6, 4'h6, 4'h6, 4'h5};
    cfg(8'h00);
    for (int m = 0; m < 5; m++) begin
      src_i[3:0] <= 4'h0;
      apb(1, ADDR_CONTROL, 32'h83 + m);
      for (int s = 0; s < 4; s++) begin
        src_i[3:0] <= sq[m][15 - 4 * s -: 4];
        tick(3);
        chk("store", ex[m][3 - s], out_o);
      end
      apb(1, ADDR_CONTROL, 0);
    end
    $display("t_store done");
  endtask
  // Top source, reserved code, empty gates, disable
  task automatic t_misc;
    cfg(8'h02);
    apb(1, ADDR_SEL_BASE, 32'h24);
    apb(1, ADDR_GATE_BASE + 8'h04, 0);
    apb(1, ADDR_GATE_BASE + 8'h08, 0);
    apb(1, ADDR_CONTROL, 32'h80);
    src_i <= {3'h0, 1'b1, 36'h0};
    tick(3);
    chk("src36", 1, out_o);
    apb(1, ADDR_SEL_BASE, 32'h25);
    src_i <= '1;
    tick(3);
    chk("reserved", 0, out_o);
    apb(1, ADDR_SEL_BASE, 32'h24);
    tick(3);
    chk("src36 again", 1, out_o);
    apb(1, ADDR_CONTROL, 0);
    tick(3);
    chk("disabled", 0, out_o);
    $display("t_misc done");
  endtask
  task automatic t_irq;
    cfg(8'h00);
    src_i[3:0] <= 4'h0;
    apb(1, ADDR_CONTROL, 32'h92);
    apb(1, ADDR_IRQ_STATUS, 1);
    src_i[3:0] <= 4'hF;
    tick(4);
    chk("rise", 1, flag_o);
    src_i[3:0] <= 4'h0;
    tick(4);
    chk("sticky", 1, flag_o);
    apb(1, ADDR_IRQ_STATUS, 1);
    tick(1);
    chk("clear", 0, flag_o);
    apb(1, ADDR_CONTROL, 32'h8A);
    src_i[3:0] <= 4'hF;
    tick(4);
    chk("no rise", 0, flag_o);
    src_i[3:0] <= 4'h0;
    tick(4);
    chk("fall", 1, flag_o);
    // Rising edge lands on the very edge that carries the clear
    apb(1, ADDR_CONTROL, 32'h92);
    fork
      apb(1, ADDR_IRQ_STATUS, 1);
      begin
        tick(1);
        src_i[3:0] <= 4'hF;
      end
    join
    tick(1);
    chk("edge in clear", 1, flag_o);
    $display("t_irq done");
  endtask
  // Frozen write, then reset keeps gate enable state
  task automatic t_rst;
    apb(1, ADDR_GATE_BASE, 32'hA5);
    ce_i <= 1'b0;
    apb(1, ADDR_GATE_BASE, 32'h00);
    ce_i <= 1'b1;
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    apb(0, ADDR_GATE_BASE, 0);
    chk("kept", 32'hA5, rd);
    apb(0, ADDR_CONTROL, 0);
    chk("ctrl", 0, rd);
    chk("flag", 0, flag_o);
    $display("t_rst done");
  endtask
  initial begin
    tick(16);
    rst_n_i <= 1'b1;
    t_regs();
    t_comb();
    t_store();
    t_misc();
    t_irq();
    t_rst();
    report_and_stop();
  end
endmodule // cfl_cell_tb
